// *** scdt_map.svh ***
// How it works
// - master bit clock is clock over 2(div+1)
// - data write goes into transmit buffer
// - master data write starts a transfer
// - data read returns the receive buffer
// - serial clock inverted when polarity is 1
// - slave drives MISO within four clocks
// - slave releases MISO within four clocks
// - slave MISO next bit within four clocks
// - phase 1 slave MISO changes 6-8 clocks
// - receive empty flag set once read; master 1
// - slave samples MOSI at bit centre
`ifndef SCDT_MAP_SVH
`define SCDT_MAP_SVH
// ==========================================
// register map
`define SCDT_DIV_ADDR   8'ha2
`define SCDT_DATA_ADDR  8'ha3
`define SCDT_DIV_RST    8'h00
`define SCDT_DATA_RST   8'h00
// ==========================================
// shift and timing counts
`define SCDT_LAST_BIT   3'd7
`define SCDT_SLH_CYC    3'd6
`endif

// *** scdt_pkg.sv ***
package scdt_pkg;
  // register port request, one cycle strobes
  typedef struct packed {
    logic [7:0] addr;
    logic       wr;
    logic       rd;
    logic [7:0] wdata;
  } scdt_sfr_req_t;
  // master engine, gray along idle-run
  typedef enum logic [1:0] {
    SCDT_IDLE = 2'b00,
    SCDT_RUN  = 2'b01
  } scdt_state_t;
endpackage : scdt_pkg

// *** scdt_slave_model.sv ***
`timescale 1ns/1ns
`default_nettype none

// ==========================================
// external slave facing a master transfer
module scdt_slave_model (
  // serial pins
  input  wire logic       i_sck,
  input  wire logic       i_mosi,
  input  wire logic       i_ss_n,
  // mode and byte to send
  input  wire logic       i_cpol,
  input  wire logic       i_cpha,
  input  wire logic [7:0] i_tx,
  // line and byte received
  output logic            o_miso,
  output logic [7:0]      o_rx
);
  logic [7:0] sh;   // bits still to send
  logic       lead; // edge leaving idle level

  initial o_miso = 1'b0;
  // load on select, phase 0 shows first bit at once
  always @(negedge i_ss_n) begin
    sh = i_tx;
    if (!i_cpha) begin
      o_miso = sh[7];
      sh = sh << 1;
    end
  end
  // released line shows the inverse, never a stale bit
  always @(posedge i_ss_n) o_miso = ~o_miso;
  // sample on one edge kind, shift on the other
  always @(i_sck) begin
    lead = (i_sck != i_cpol);
    if (!i_ss_n && lead != i_cpha) begin
      o_rx = {o_rx[6:0], i_mosi};
    end else if (!i_ss_n) begin
      o_miso = sh[7];
      sh = sh << 1;
    end
  end
endmodule : scdt_slave_model
`default_nettype wire

// *** scdt_top.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "scdt_map.svh"

// ==========================================
// transmit fifo
module scdt_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  // clock and reset
  input  wire logic                       i_core_clk,
  input  wire logic                       i_reset,
  // fill side
  input  wire logic                       i_valid,
  output logic                            o_ready,
  input  wire logic [WIDTH-1:0]           i_data,
  // drain side
  output logic                            o_valid,
  input  wire logic                       i_ready,
  output logic [WIDTH-1:0]                o_data,
  output logic [$clog2(DEPTH):0]          o_count
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];  // storage
  logic [AW-1:0]    wp;           // write pointer
  logic [AW-1:0]    rp;           // read pointer
  logic             push;
  logic             pop;

  assign o_ready = (o_count != (AW+1)'(DEPTH));
  assign o_valid = (o_count != '0);
  assign o_data  = mem[rp];
  assign push    = i_valid & o_ready;
  assign pop     = o_valid & i_ready;

  // storage has no reset, only pointers matter
  always_ff @(posedge i_core_clk) begin
    if (push) begin
      mem[wp] <= i_data;
    end
  end

  // pointers and occupancy
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      wp      <= '0;
      rp      <= '0;
      o_count <= '0;
    end else begin
      if (push) begin
        wp <= wp + 1'b1;
      end
      if (pop) begin
        rp <= rp + 1'b1;
      end
      o_count <= o_count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : scdt_fifo

// ==========================================
// serial engine with divider and data register
module scdt_top
  import scdt_pkg::*;
#(
  parameter int TX_DEPTH = 32
) (
  // clock and reset
  input  wire logic           i_core_clk,
  input  wire logic           i_reset,
  // register port
  input  wire scdt_sfr_req_t  i_sfr,
  output logic [7:0]          o_sfr_rdata,
  output logic                o_tx_ready,
  // control from the rest of the unit
  input  wire logic           i_spi_enable,
  input  wire logic           i_master_mode,
  input  wire logic           i_clock_polarity_select,
  input  wire logic           i_clock_phase_select,
  // status to the rest of the unit
  output logic                o_byte_done,
  output logic                o_receive_buffer_empty_flag,
  output logic                o_busy,
  // serial pins, enables low while driving
  input  wire logic           i_slave_select_n,
  input  wire logic           i_sck_in,
  output logic                o_sck_out,
  output logic                o_sck_oe_n,
  input  wire logic           i_mosi_in,
  output logic                o_mosi_out,
  output logic                o_mosi_oe_n,
  input  wire logic           i_miso_in,
  output logic                o_miso_out,
  output logic                o_miso_oe_n
);
  logic [7:0]  clock_divider_value;  // divider register
  logic [7:0]  rx_buf;               // receive buffer
  logic        rx_unread;            // unread byte waiting
  scdt_state_t state;                // master engine state
  logic [7:0]  hcnt;                 // half period counter
  logic        sck_ph;               // 0 = idle level
  logic [7:0]  tx_sh;                // outgoing shifter
  logic [7:0]  rx_sh;                // incoming shifter
  logic [2:0]  bits;                 // samples taken in byte
  logic        sck_prev;             // last sampled slave clock
  logic        nss_prev;             // last sampled select
  logic [2:0]  slh_cnt;              // phase 1 reload delay
  logic        miso_drv;             // slave owns MISO
  logic        f_valid;
  logic [7:0]  f_data;
  logic [$clog2(TX_DEPTH):0] f_count;
  logic        slave;
  logic        wr_data;
  logic        rd_data;
  logic        m_edge;
  logic        s_edge;
  logic        edge_ev;
  logic        lead;
  logic        sample_ev;
  logic        shift_ev;
  logic        byte_done;
  logic        start;
  logic        nss_fall;
  logic        slh_fire;
  logic        load;
  logic        pop;

  // ==========================================
  // decode and event terms
  assign slave     = i_spi_enable & ~i_master_mode;
  assign wr_data   = i_sfr.wr & (i_sfr.addr == `SCDT_DATA_ADDR);
  assign rd_data   = i_sfr.rd & (i_sfr.addr == `SCDT_DATA_ADDR);
  assign m_edge    = (state == SCDT_RUN) & (hcnt == clock_divider_value);
  assign s_edge    = slave & ~i_slave_select_n & (i_sck_in != sck_prev);
  assign edge_ev   = i_master_mode ? m_edge : s_edge;
  // leading edge leaves the idle level
  assign lead      = i_master_mode ? ~sck_ph : (sck_prev == i_clock_polarity_select);
  // slave sampling edge sits mid-bit
  assign sample_ev = edge_ev & (lead ^ i_clock_phase_select);
  // shift edge skipped while bits is 0: first one in phase 1 (msb already out), the one after the last sample in phase 0
  assign shift_ev  = edge_ev & ~(lead ^ i_clock_phase_select) & (bits != 3'd0);
  assign byte_done = sample_ev & (bits == `SCDT_LAST_BIT);
  // a write alone starts the master once the fifo shows it
  assign start     = i_spi_enable & i_master_mode & (state == SCDT_IDLE) & f_valid;
  assign nss_fall  = slave & nss_prev & ~i_slave_select_n;
  assign slh_fire  = (slh_cnt == 3'd1);
  assign load      = start | nss_fall | (slave & byte_done & ~i_clock_phase_select) | slh_fire;
  assign pop       = load & f_valid;
  assign o_busy    = (state == SCDT_RUN);
  assign o_byte_done = byte_done;

  // transmit buffer; writes while full are dropped, ready shows room
  scdt_fifo #(
    .WIDTH (8),
    .DEPTH (TX_DEPTH)
  ) u_tx_fifo (
    .i_core_clk (i_core_clk),
    .i_reset    (i_reset),
    .i_valid    (wr_data),
    .o_ready    (o_tx_ready),
    .i_data     (i_sfr.wdata),
    .o_valid    (f_valid),
    .i_ready    (load),
    .o_data     (f_data),
    .o_count    (f_count)
  );

  // ==========================================
  // register port
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      clock_divider_value <= `SCDT_DIV_RST;
    end else if (i_sfr.wr && i_sfr.addr == `SCDT_DIV_ADDR) begin
      clock_divider_value <= i_sfr.wdata;
    end
  end

  // read data registered; unmapped reads give zero
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      o_sfr_rdata <= 8'h00;
    end else if (rd_data) begin
      o_sfr_rdata <= rx_buf;
    end else if (i_sfr.rd && i_sfr.addr == `SCDT_DIV_ADDR) begin
      o_sfr_rdata <= clock_divider_value;
    end else if (i_sfr.rd) begin
      o_sfr_rdata <= 8'h00;
    end
  end

  // receive buffer; a new byte wins over a same-cycle read
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      rx_buf    <= `SCDT_DATA_RST;
      rx_unread <= 1'b0;
    end else if (byte_done) begin
      rx_buf    <= {rx_sh[6:0], i_master_mode ? i_miso_in : i_mosi_in};
      rx_unread <= 1'b1;
    end else if (rd_data) begin
      rx_unread <= 1'b0;
    end
  end
  assign o_receive_buffer_empty_flag = i_master_mode | ~rx_unread;

  // ==========================================
  // master bit clock
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      state  <= SCDT_IDLE;
      hcnt   <= 8'h00;
      sck_ph <= 1'b0;
    end else begin
      case (state)
        SCDT_IDLE: begin
          hcnt   <= 8'h00;
          sck_ph <= 1'b0;
          if (start) begin
            state <= SCDT_RUN;
          end
        end
        SCDT_RUN: begin
          if (m_edge) begin
            // each half period lasts div+1 clocks
            hcnt   <= 8'h00;
            sck_ph <= ~sck_ph;
            // sixteenth edge returns the clock to idle
            if (sck_ph && bits == 3'd0 && !i_clock_phase_select) begin
              state <= SCDT_IDLE;
            end
            if (byte_done && i_clock_phase_select) begin
              state <= SCDT_IDLE;
            end
          end else begin
            hcnt <= hcnt + 8'h01;
          end
          if (!i_spi_enable || !i_master_mode) begin
            state <= SCDT_IDLE;
          end
        end
        default: begin
          state <= SCDT_IDLE;
        end
      endcase
    end
  end

  // ==========================================
  // shift datapath shared by both roles
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      tx_sh <= 8'h00;
      rx_sh <= 8'h00;
      bits  <= 3'd0;
    end else begin
      if (load) begin
        tx_sh <= f_valid ? f_data : 8'h00;
      end else if (shift_ev) begin
        tx_sh <= {tx_sh[6:0], 1'b0};
      end
      if (sample_ev) begin
        rx_sh <= {rx_sh[6:0], i_master_mode ? i_miso_in : i_mosi_in};
        bits  <= bits + 3'd1;
      end else if (slave && i_slave_select_n) begin
        bits <= 3'd0;  // frame over, realign
      end
    end
  end

  // slave pin history, select idles high
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      sck_prev <= 1'b0;
      nss_prev <= 1'b1;
    end else begin
      sck_prev <= i_sck_in;
      nss_prev <= i_slave_select_n;
    end
  end

  // phase 1: hold the last bit, then present next byte
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      slh_cnt <= 3'd0;
    end else if (!slave || i_slave_select_n) begin
      slh_cnt <= 3'd0;
    end else if (byte_done && i_clock_phase_select) begin
      slh_cnt <= `SCDT_SLH_CYC;
    end else if (slh_cnt != 3'd0) begin
      slh_cnt <= slh_cnt - 3'd1;
    end
  end

  // MISO ownership follows select one clock later
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      miso_drv <= 1'b0;
    end else begin
      miso_drv <= slave & ~i_slave_select_n;
    end
  end

  // ==========================================
  // pins
  assign o_sck_out   = i_clock_polarity_select ^ sck_ph;
  assign o_sck_oe_n  = ~(i_spi_enable & i_master_mode);
  assign o_mosi_out  = tx_sh[7];
  assign o_mosi_oe_n = ~(i_spi_enable & i_master_mode);
  assign o_miso_out  = tx_sh[7];
  assign o_miso_oe_n = ~miso_drv;

  // ==========================================
  // checks
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_reset);

  property p_div;
    (state == SCDT_RUN && !start) |=> (sck_ph != $past(sck_ph)) == $past(m_edge) || state == SCDT_IDLE;
  endproperty
  a_div: assert property (p_div) else $error("bit clock not on divider");
  property p_push;
    (wr_data && o_tx_ready && !pop) |=> f_count == $past(f_count) + 1'b1;
  endproperty
  a_push: assert property (p_push) else $error("data write lost");
  property p_start;
    (i_spi_enable && i_master_mode && state == SCDT_IDLE && !f_valid && wr_data) ##1 i_master_mode
      |=> state == SCDT_RUN;
  endproperty
  a_start: assert property (p_start) else $error("write did not start transfer");
  property p_read;
    rd_data |=> o_sfr_rdata == $past(rx_buf);
  endproperty
  a_read: assert property (p_read) else $error("read not from receive buffer");
  property p_pol;
    (state == SCDT_IDLE && $changed(i_clock_polarity_select)) |-> $changed(o_sck_out);
  endproperty
  a_pol: assert property (p_pol) else $error("clock ignores polarity");
  property p_drive;
    (slave && $fell(i_slave_select_n)) ##1 !i_slave_select_n |-> ##[0:3] !o_miso_oe_n;
  endproperty
  a_drive: assert property (p_drive) else $error("MISO not driven in time");
  property p_release;
    $rose(i_slave_select_n) |-> ##[1:4] o_miso_oe_n;
  endproperty
  a_release: assert property (p_release) else $error("MISO not released in time");
  property p_shift;
    (slave && shift_ev && !load) |=> tx_sh == {$past(tx_sh[6:0]), 1'b0};
  endproperty
  a_shift: assert property (p_shift) else $error("MISO did not advance");
  property p_slh;
    (slave && byte_done && i_clock_phase_select && !i_slave_select_n) |-> ##6 (slh_fire || i_slave_select_n || !slave);
  endproperty
  a_slh: assert property (p_slh) else $error("last bit hold wrong");
  property p_empty;
    (slave && rd_data && !byte_done) |=> o_receive_buffer_empty_flag || !slave;
  endproperty
  a_empty: assert property (p_empty) else $error("empty flag not set on read");
  property p_centre;
    (slave && sample_ev) |=> rx_sh[0] == $past(i_mosi_in);
  endproperty
  a_centre: assert property (p_centre) else $error("MOSI not sampled");
  property p_idle;
    state == SCDT_IDLE |-> o_sck_out == i_clock_polarity_select;
  endproperty
  a_idle: assert property (p_idle) else $error("clock not idle");
endmodule : scdt_top
`default_nettype wire

// *** scdt_top_bench.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "scdt_map.svh"

// ==========================================
// bench: register calls and serial traffic
module scdt_top_bench;
  import scdt_pkg::*;
  logic          clk = 0;            // core clock
  logic          rst = 1;            // sync reset
  scdt_sfr_req_t sfr = '0;           // register request
  logic          en = 1, mst = 1;    // enable and mode
  logic          cpol = 0, cpha = 0; // clock shape
  logic          ss_n = 1, mss_n = 1; // design and model selects
  logic          tsck = 0, tmosi = 0; // bench as master
  logic [7:0]    rdata, tx_r, m_tx = 0, m_rx, got, dv;
  logic          tx_rdy, done, empty, busy;
  logic          sck_o, sck_oe_n, mosi_o, mosi_oe_n, miso_o, miso_oe_n, m_miso;
  wire logic     sck_w  = !sck_oe_n ? sck_o : tsck;
  wire logic     mosi_w = !mosi_oe_n ? mosi_o : tmosi;
  wire logic     miso_w = !miso_oe_n ? miso_o : m_miso;
  int            n_mismatch = 0, checked = 0;
  logic [15:0]   n, e, nd;           // cycle, edge and byte-done counts
  logic          last;
  logic [7:0]    divs [4] = '{8'h01, 8'h02, 8'h04, 8'hff}; // incl. top value

  always #20 clk = ~clk;

  scdt_top i_dut (.i_core_clk(clk), .i_reset(rst), .i_sfr(sfr), .o_sfr_rdata(rdata),
    .o_tx_ready(tx_rdy), .i_spi_enable(en), .i_master_mode(mst),
    .i_clock_polarity_select(cpol), .i_clock_phase_select(cpha), .o_byte_done(done),
    .o_receive_buffer_empty_flag(empty), .o_busy(busy), .i_slave_select_n(ss_n),
    .i_sck_in(sck_w), .o_sck_out(sck_o), .o_sck_oe_n(sck_oe_n), .i_mosi_in(mosi_w),
    .o_mosi_out(mosi_o), .o_mosi_oe_n(mosi_oe_n), .i_miso_in(miso_w),
    .o_miso_out(miso_o), .o_miso_oe_n(miso_oe_n));

  scdt_slave_model i_model (.i_sck(sck_w), .i_mosi(mosi_w), .i_ss_n(mss_n),
    .i_cpol(cpol), .i_cpha(cpha), .i_tx(m_tx), .o_miso(m_miso), .o_rx(m_rx));

  // ==========================================
  // shared tasks
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask : cyc

  // wide enough that a 256-clock half period does not wrap
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sfr.addr = a;
    sfr.wdata = d;
    sfr.wr = 1;
    cyc(1);
    sfr.wr = 0;
    // gap cycle: back to back calls never lower and raise the strobe at once
    cyc(1);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    sfr.addr = a;
    sfr.rd = 1;
    cyc(1);
    sfr.rd = 0;
    d = rdata;
    // gap cycle, as for writes
    cyc(1);
  endtask : rd

  // bench as master: 6-clock half periods, mosi moved mid-gap
  task automatic spi_m(input logic [7:0] b, output logic [7:0] r);
    // park the clock first, so a polarity change is no edge inside the frame
    tsck = cpol;
    cyc(1);
    ss_n = 0;
    cyc(4);
    chk("miso enable", miso_oe_n, 0);
    for (int i = 7; i >= 0; i--) begin
      if (cpha) begin
        tsck = ~tsck;
        cyc(3);
      end
      tmosi = b[i];
      cyc(3);
      r[i] = miso_w;
      tsck = ~tsck;
      cyc(6);
      if (!cpha) begin
        tsck = ~tsck;
        cyc(3);
      end
    end
    cyc(3);
    ss_n = 1;
    cyc(4);
    chk("miso release", miso_oe_n, 1);
  endtask : spi_m

  task automatic results;
    $display("checked %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : results

  // watchdog, about five times the expected run
  initial begin
    #(40000 * 40);
    n_mismatch++;
    results();
  end

  // ==========================================
  // tests
  initial begin
    cyc(10);
    rst = 0;
    rd(`SCDT_DIV_ADDR, got);
    chk("divider reset", got, `SCDT_DIV_RST);
    rd(`SCDT_DATA_ADDR, got);
    chk("data reset", got, `SCDT_DATA_RST);
    rd(8'h55, got);
    chk("unmapped read", got, 8'h00);
    chk("empty flag master", empty, 1);
    $display("test reset done");
    // every polarity and phase, a different divider each
    for (int m = 0; m < 4; m++) begin
      cpol = m[1];
      cpha = m[0];
      wr(`SCDT_DIV_ADDR, divs[m]);
      rd(`SCDT_DIV_ADDR, got);
      chk("divider", got, divs[m]);
      chk("sck idle", sck_w, cpol);
      m_tx = 8'h3c + m;
      mss_n = 0;
      wr(`SCDT_DATA_ADDR, 8'ha5 ^ m);
      n = 0;
      e = 0;
      nd = 0;
      last = sck_w;
      for (int k = 0; k < 5000; k++) begin
        cyc(1);
        n++;
        if (done === 1'b1) nd++;
        if (sck_w !== last) begin
          if (e > 0) chk("half period", n, divs[m] + 8'h01);
          e++;
          n = 0;
          last = sck_w;
        end
        if (e == 16 && busy === 1'b0) break;
      end
      chk("edge count", e, 8'd16);
      chk("byte done", nd, 16'h0001);
      chk("sck idle after", sck_w, cpol);
      mss_n = 1;
      chk("slave got", m_rx, 8'ha5 ^ m);
      rd(`SCDT_DATA_ADDR, got);
      chk("master rx", got, 8'h3c + m);
      chk("empty flag master", empty, 1);
    end
    $display("test master done");
    // slave: fill the buffer until refused, then drain past empty
    mst = 0;
    cyc(2);
    for (int i = 0; i < 32; i++) begin
      chk("tx ready", tx_rdy, 1);
      wr(`SCDT_DATA_ADDR, 8'h40 + i);
    end
    chk("tx full", tx_rdy, 0);
    wr(`SCDT_DATA_ADDR, 8'hee);
    for (int i = 0; i < 33; i++) begin
      cpol = i[1];
      cpha = i[0];
      dv = 8'h96 ^ i;
      spi_m(dv, got);
      // each frame takes two words: one at select fall, one after the last bit
      chk("slave tx", got, (i < 16) ? 8'h40 + 8'h02 * i : 8'h00);
      chk("empty unread", empty, 0);
      rd(`SCDT_DATA_ADDR, got);
      chk("slave rx", got, dv);
      cyc(1);
      chk("empty read", empty, 1);
    end
    $display("test slave done");
    results();
  end
endmodule : scdt_top_bench
`default_nettype wire
